// ==== core/adc_channel_calibration_regs.sv ====
// trim and channel 1 setup register bank with apb slave and trim datapath
// assumes raw samples arrive synchronous to pclk, one valid pulse each
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "calib_params.svh"
module adc_channel_calibration_regs (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // raw conversion results
   input calib_pkg::sample_t chan0_raw,
   input calib_pkg::sample_t chan1_raw,
   // calibrated results
   output calib_pkg::sample_t chan0_cal,
   output calib_pkg::sample_t chan1_cal,
   // channel 1 front-end controls and global dc filter setting
   output logic [9:0] chan1_delay_trim,
   output logic [3:0] chan1_input_route,
   output logic chan1_dc_filter_bypass,
   output logic [3:0] chan1_dc_filter_setting,
   output logic [3:0] global_dc_filter_setting
);

   calib_pkg::bus_state_t state_r, state_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [15:0] prdata_r, prdata_nxt;

   logic setup;
   logic hit;
   logic wr_fire;
   logic [7:0] idx;
   logic [15:0] rd_word;

   logic [15:0] o0_hi_r, o0_hi_nxt;
   logic [7:0] o0_lo_r, o0_lo_nxt;
   logic [15:0] g0_hi_r, g0_hi_nxt;
   logic [7:0] g0_lo_r, g0_lo_nxt;
   calib_pkg::chan1_setup_t c1_r, c1_nxt;
   logic [15:0] o1_hi_r, o1_hi_nxt;
   logic [7:0] o1_lo_r, o1_lo_nxt;
   logic [3:0] dc_r, dc_nxt;

   calib_pkg::trim_t trim0;
   calib_pkg::trim_t trim1;

   // address decode and read mux
   always_comb begin
      idx = paddr[9:2];
      setup = psel && !penable;
      hit = 1'b1;
      rd_word = 16'h0000;
      case (idx)
         `IDX_DC_SETTING: begin
            rd_word = {12'h000, dc_r};
         end
         `IDX_C0_OFS_HI: begin
            rd_word = o0_hi_r;
         end
         `IDX_C0_OFS_LO: begin
            rd_word = {o0_lo_r, 8'h00};
         end
         `IDX_C0_GAIN_HI: begin
            rd_word = g0_hi_r;
         end
         `IDX_C0_GAIN_LO: begin
            rd_word = {g0_lo_r, 8'h00};
         end
         `IDX_C1_SETUP: begin
            rd_word = {c1_r.delay, 3'h0, c1_r.bypass, c1_r.sel};
         end
         `IDX_C1_OFS_HI: begin
            rd_word = o1_hi_r;
         end
         `IDX_C1_OFS_LO: begin
            rd_word = {o1_lo_r, 8'h00};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      // misaligned or out-of-window addresses are errors, not aliases
      if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
         hit = 1'b0;
      end
      wr_fire = (state_r == calib_pkg::BUS_ACK) && psel && penable && pwrite && !pslverr_r;
   end

   // apb handshake: setup is answered by pready in the first access cycle
   always_comb begin
      state_nxt = state_r;
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      prdata_nxt = prdata_r;
      case (state_r)
         calib_pkg::BUS_IDLE: begin
            if (setup) begin
               state_nxt = calib_pkg::BUS_ACK;
               pready_nxt = 1'b1;
               pslverr_nxt = !hit;
               prdata_nxt = (!pwrite && hit) ? rd_word : 16'h0000;
            end
         end
         calib_pkg::BUS_ACK: begin
            state_nxt = calib_pkg::BUS_IDLE;
         end
         default: begin
            state_nxt = calib_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= calib_pkg::BUS_IDLE;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= `RST_WORD;
      end else begin
         state_r <= state_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // register writes; reserved low bytes are never stored
   always_comb begin
      o0_hi_nxt = o0_hi_r;
      o0_lo_nxt = o0_lo_r;
      g0_hi_nxt = g0_hi_r;
      g0_lo_nxt = g0_lo_r;
      c1_nxt = c1_r;
      o1_hi_nxt = o1_hi_r;
      o1_lo_nxt = o1_lo_r;
      dc_nxt = dc_r;
      if (wr_fire) begin
         case (idx)
            `IDX_DC_SETTING: begin
               dc_nxt = pwdata[`DC_MSB:0];
            end
            `IDX_C0_OFS_HI: begin
               o0_hi_nxt = pwdata[15:0];
            end
            `IDX_C0_OFS_LO: begin
               o0_lo_nxt = pwdata[`LO_FIELD_MSB:`LO_FIELD_LSB];
            end
            `IDX_C0_GAIN_HI: begin
               g0_hi_nxt = pwdata[15:0];
            end
            `IDX_C0_GAIN_LO: begin
               g0_lo_nxt = pwdata[`LO_FIELD_MSB:`LO_FIELD_LSB];
            end
            `IDX_C1_SETUP: begin
               c1_nxt.delay = pwdata[`DELAY_MSB:`DELAY_LSB];
               c1_nxt.bypass = pwdata[`BYPASS_BIT];
               c1_nxt.sel = calib_pkg::input_sel_t'(pwdata[`SEL_MSB:0]);
            end
            `IDX_C1_OFS_HI: begin
               o1_hi_nxt = pwdata[15:0];
            end
            `IDX_C1_OFS_LO: begin
               o1_lo_nxt = pwdata[`LO_FIELD_MSB:`LO_FIELD_LSB];
            end
            default: begin
               dc_nxt = dc_r;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         o0_hi_r <= `RST_WORD;
         o0_lo_r <= `RST_BYTE;
         g0_hi_r <= `RST_GAIN_HI;
         g0_lo_r <= `RST_BYTE;
         c1_r <= `RST_SETUP;
         o1_hi_r <= `RST_WORD;
         o1_lo_r <= `RST_BYTE;
         dc_r <= `RST_DC;
      end else begin
         o0_hi_r <= o0_hi_nxt;
         o0_lo_r <= o0_lo_nxt;
         g0_hi_r <= g0_hi_nxt;
         g0_lo_r <= g0_lo_nxt;
         c1_r <= c1_nxt;
         o1_hi_r <= o1_hi_nxt;
         o1_lo_r <= o1_lo_nxt;
         dc_r <= dc_nxt;
      end
   end

   // channel 1 gain lives outside this bank, so it runs at unity here
   always_comb begin
      trim0.offset = {o0_hi_r, o0_lo_r};
      trim0.gain = {g0_hi_r, g0_lo_r};
      trim1.offset = {o1_hi_r, o1_lo_r};
      trim1.gain = `UNITY_GAIN;
   end

   calib_apply u_apply0 (
      .pclk(pclk),
      .presetn(presetn),
      .raw(chan0_raw),
      .trim(trim0),
      .cooked(chan0_cal)
   );

   calib_apply u_apply1 (
      .pclk(pclk),
      .presetn(presetn),
      .raw(chan1_raw),
      .trim(trim1),
      .cooked(chan1_cal)
   );

   input_route u_route (
      .pclk(pclk),
      .presetn(presetn),
      .sel(c1_r.sel),
      .bypass(c1_r.bypass),
      .global_dc(dc_r),
      .route(chan1_input_route),
      .dc_eff(chan1_dc_filter_setting)
   );

   assign prdata = {16'h0000, prdata_r};
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign chan1_delay_trim = c1_r.delay;
   assign chan1_dc_filter_bypass = c1_r.bypass;
   assign global_dc_filter_setting = dc_r;

   bus_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && state_r == calib_pkg::BUS_IDLE) |=> pready)
      else $error("setup not answered in first access cycle");
   ofs_hi_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_fire && idx == `IDX_C0_OFS_HI) |=> (o0_hi_r == $past(pwdata[15:0])))
      else $error("offset high word not stored");
   ofs_lo_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && idx == `IDX_C0_OFS_LO && hit)
      |=> (prdata[7:0] == 8'h00 && prdata[15:8] == $past(o0_lo_r)))
      else $error("offset low register read wrong");
   gain_lo_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_fire && idx == `IDX_C0_GAIN_LO)
      |=> (g0_lo_r == $past(pwdata[15:8]) && g0_hi_r == $past(g0_hi_r)))
      else $error("gain low byte not stored alone");
   gain_reset_a: assert property (@(posedge pclk)
      $rose(presetn) |-> (g0_hi_r == 16'h8000 && g0_lo_r == 8'h00))
      else $error("gain not unity after reset");
   setup_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && idx == `IDX_C1_SETUP && hit)
      |=> (prdata[5:3] == 3'h0 && prdata[15:6] == $past(c1_r.delay)))
      else $error("setup register read wrong");
   ofs1_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_fire && idx == `IDX_C1_OFS_LO) |=> (o1_lo_r == $past(pwdata[15:8])))
      else $error("channel 1 offset low byte not stored");
   setup_reset_a: assert property (@(posedge pclk)
      $rose(presetn) |-> (c1_r == 13'h0000 && chan1_input_route == 4'h1))
      else $error("setup register not cleared by reset");
   pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready held longer than one cycle");
   refused_access_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && state_r == calib_pkg::BUS_IDLE && !hit)
      |=> (pready && pslverr && prdata == 32'h00000000))
      else $error("refused access not answered with error and zero data");
   refused_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pslverr && psel && penable && pwrite)
      |=> ($stable(o0_hi_r) && $stable(dc_r) && $stable(c1_r)))
      else $error("refused write changed a register");
   ofs0_lo_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_fire && idx == `IDX_C0_OFS_LO) |=> (o0_lo_r == $past(pwdata[15:8])))
      else $error("channel 0 offset low byte not stored");
   dc_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_fire && idx == `IDX_DC_SETTING) |=> (dc_r == $past(pwdata[3:0])))
      else $error("global dc setting not stored");
   setup_fields_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_fire && idx == `IDX_C1_SETUP)
      |=> (c1_r.bypass == $past(pwdata[2]) && c1_r.sel == $past(pwdata[1:0])))
      else $error("setup bypass or input select not stored");

endmodule // adc_channel_calibration_regs

// ==== core/calib_params.svh ====
// register indices, field positions, reset values and scaling for the trim bank
// assumes each register index maps to byte address index*4 on apb
`ifndef CALIB_PARAMS_SVH
`define CALIB_PARAMS_SVH

// register indices (byte address = index * 4)
`define IDX_DC_SETTING 8'h08
`define IDX_C0_OFS_HI 8'h0A
`define IDX_C0_OFS_LO 8'h0B
`define IDX_C0_GAIN_HI 8'h0C
`define IDX_C0_GAIN_LO 8'h0D
`define IDX_C1_SETUP 8'h0E
`define IDX_C1_OFS_HI 8'h0F
`define IDX_C1_OFS_LO 8'h10

// reset values
`define RST_WORD 16'h0000
`define RST_GAIN_HI 16'h8000
`define RST_BYTE 8'h00
`define RST_DC 4'h0
`define RST_SETUP 13'h0000

// field positions
`define LO_FIELD_MSB 15
`define LO_FIELD_LSB 8
`define DELAY_MSB 15
`define DELAY_LSB 6
`define BYPASS_BIT 2
`define SEL_MSB 1
`define DC_MSB 3

// gain is q1.23: 800000h is unity
`define GAIN_FRAC 23
`define UNITY_GAIN 24'h800000
`define SAT_POS 24'h7FFFFF
`define SAT_NEG 24'h800000

`endif

// ==== core/calib_pkg.sv ====
// types shared by the trim register bank and its datapath
// assumes calib_params.svh holds all numeric constants
package calib_pkg;

   typedef enum logic [1:0] {
      SEL_PINS = 2'h0,
      SEL_SHORT = 2'h1,
      SEL_POS_TEST = 2'h2,
      SEL_NEG_TEST = 2'h3
   } input_sel_t;

   typedef struct packed {
      logic [9:0] delay;
      logic bypass;
      input_sel_t sel;
   } chan1_setup_t;

   typedef struct packed {
      logic [23:0] offset;
      logic [23:0] gain;
   } trim_t;

   typedef struct packed {
      logic valid;
      logic [23:0] data;
   } sample_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_ACK = 2'h1
   } bus_state_t;

endpackage

// ==== core/calib_apply.sv ====
// one channel of trim: subtract offset, scale by q1.23 gain, saturate
// assumes trim values are stable registers; one cycle of latency
`timescale 1ns/1ps
`include "calib_params.svh"
module calib_apply (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // raw sample and trim
   input calib_pkg::sample_t raw,
   input calib_pkg::trim_t trim,
   // calibrated sample
   output calib_pkg::sample_t cooked
);

   logic signed [24:0] diff;
   logic signed [49:0] prod;
   logic signed [26:0] scaled;
   logic [23:0] sat;
   calib_pkg::sample_t out_r, out_nxt;

   always_comb begin
      // offset first so the gain also scales the residual error
      diff = $signed({raw.data[23], raw.data}) - $signed({trim.offset[23], trim.offset});
      prod = diff * $signed({1'b0, trim.gain});
      scaled = prod[49:`GAIN_FRAC];
      if (scaled[26:23] == {4{scaled[26]}}) begin
         sat = scaled[23:0];
      end else if (scaled[26]) begin
         sat = `SAT_NEG;
      end else begin
         sat = `SAT_POS;
      end
      out_nxt.valid = raw.valid;
      out_nxt.data = raw.valid ? sat : out_r.data;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_r <= '0;
      end else begin
         out_r <= out_nxt;
      end
   end

   assign cooked = out_r;

   unity_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      (raw.valid && trim.offset == 24'h000000 && trim.gain == `UNITY_GAIN)
      |=> (cooked.valid && cooked.data == $past(raw.data)))
      else $error("unity trim did not pass the sample through");

endmodule // calib_apply

// ==== core/input_route.sv ====
// channel 1 front-end decode: input routing and effective dc filter setting
// assumes setup fields come straight from registers
`timescale 1ns/1ps
module input_route (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // settings
   input calib_pkg::input_sel_t sel,
   input wire logic bypass,
   input wire logic [3:0] global_dc,
   // decoded controls, one-hot pins/short/pos/neg from bit 0 up
   output logic [3:0] route,
   output logic [3:0] dc_eff
);

   logic [3:0] route_r, route_nxt;
   logic [3:0] dc_r, dc_nxt;

   always_comb begin
      route_nxt = 4'h0;
      route_nxt[sel] = 1'b1;
      // zero setting means filter off for this channel
      dc_nxt = bypass ? 4'h0 : global_dc;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_r <= 4'h1;
         dc_r <= 4'h0;
      end else begin
         route_r <= route_nxt;
         dc_r <= dc_nxt;
      end
   end

   assign route = route_r;
   assign dc_eff = dc_r;

   route_short_a: assert property (@(posedge pclk) disable iff (!presetn)
      (sel == calib_pkg::SEL_SHORT) |=> (route == 4'h2))
      else $error("shorted input not routed");
   dc_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!bypass) |=> (dc_eff == $past(global_dc)))
      else $error("dc filter does not follow global setting");
   dc_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
      bypass |=> (dc_eff == 4'h0))
      else $error("dc filter not bypassed");

endmodule // input_route

// ==== testbench/adc_channel_calibration_regs_test.sv ====
// self-checking bench for the trim register bank: apb access, setup decode, trim datapath
// assumes apb slave answers with pready in the access cycle, registers at byte index*4
`timescale 1ns/1ps
module adc_channel_calibration_regs_test;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   calib_pkg::sample_t chan0_raw;
   calib_pkg::sample_t chan1_raw;
   calib_pkg::sample_t chan0_cal;
   calib_pkg::sample_t chan1_cal;
   logic [9:0] chan1_delay_trim;
   logic [3:0] chan1_input_route;
   logic chan1_dc_filter_bypass;
   logic [3:0] chan1_dc_filter_setting;
   logic [3:0] global_dc_filter_setting;
   int err_count;
   int checked;
   logic [31:0] rd;
   logic er;
   logic [11:0] addr_tab [8] = '{12'h020, 12'h028, 12'h02C, 12'h030, 12'h034, 12'h038, 12'h03C,
      12'h040};
   logic [15:0] rst_tab [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000};
   logic [15:0] ones_tab [8] = '{16'h000F, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7,
      16'hFFFF, 16'hFF00};

   adc_channel_calibration_regs uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan0_raw(chan0_raw), .chan1_raw(chan1_raw), .chan0_cal(chan0_cal),
      .chan1_cal(chan1_cal), .chan1_delay_trim(chan1_delay_trim),
      .chan1_input_route(chan1_input_route), .chan1_dc_filter_bypass(chan1_dc_filter_bypass),
      .chan1_dc_filter_setting(chan1_dc_filter_setting),
      .global_dc_filter_setting(global_dc_filter_setting)
   );

   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("counts: %0d compares, %0d mismatches", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one apb transfer; holds the request until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) check("pready wait", 32'h0, 32'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr_trim(input logic [11:0] a, input logic [23:0] v);
      apb(1'h1, a, {16'h0, v[23:8]}, rd, er);
      apb(1'h1, a + 12'h004, {16'h0, v[7:0], 8'h00}, rd, er);
   endtask

   // offset subtracted, then q1.23 gain, floor shift, saturation at full scale
   function automatic logic [23:0] cal_exp(input logic [23:0] raw, ofs, gain);
      longint d;
      d = longint'(signed'(raw)) - longint'(signed'(ofs));
      d = (d * longint'({1'h0, gain})) >>> 23;
      if (d > 64'sd8388607) return 24'h7FFFFF;
      if (d < -64'sd8388608) return 24'h800000;
      return d[23:0];
   endfunction

   task automatic run_cal(input logic ch, input logic [23:0] ofs, gain, raw);
      if (ch == 1'h0) begin
         wr_trim(12'h028, ofs);
         wr_trim(12'h030, gain);
      end else begin
         wr_trim(12'h03C, ofs);
      end
      @(posedge pclk);
      if (ch == 1'h0) chan0_raw <= '{1'h1, raw};
      else chan1_raw <= '{1'h1, raw};
      @(posedge pclk);
      chan0_raw.valid <= 1'h0;
      chan1_raw.valid <= 1'h0;
      @(negedge pclk);
      check("cal valid", ch ? chan1_cal.valid : chan0_cal.valid, 32'h1);
      check("cal data", ch ? chan1_cal.data : chan0_cal.data, cal_exp(raw, ofs, gain));
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      stop_test();
   end

   initial begin
      err_count = 0;
      checked = 0;
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      chan0_raw = '0;
      chan1_raw = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         apb(1'h0, addr_tab[i], 32'h0, rd, er);
         check("reset value", rd, {16'h0, rst_tab[i]});
         check("slave error", er, 32'h0);
      end
      $display("test reset values done");
      // all ones shows which bits are kept and which read zero
      for (int i = 0; i < 8; i++) begin
         apb(1'h1, addr_tab[i], 32'hFFFFFFFF, rd, er);
         apb(1'h0, addr_tab[i], 32'h0, rd, er);
         check("ones readback", rd, {16'h0, ones_tab[i]});
         apb(1'h1, addr_tab[i], 32'h00005A5A, rd, er);
         apb(1'h0, addr_tab[i], 32'h0, rd, er);
         check("pattern readback", rd, {16'h0, 16'h5A5A & ones_tab[i]});
      end
      $display("test field masks done");
      apb(1'h0, 12'h044, 32'h0, rd, er);
      check("unmapped error", er, 32'h1);
      check("unmapped data", rd, 32'h0);
      apb(1'h1, 12'h02A, 32'h00001234, rd, er);
      check("misaligned error", er, 32'h1);
      apb(1'h0, 12'h028, 32'h0, rd, er);
      check("misaligned ignored", rd, 32'h00005A5A);
      $display("test refused access done");
      apb(1'h1, 12'h020, 32'h0000000A, rd, er);
      for (int s = 0; s < 4; s++) begin
         apb(1'h1, 12'h038, {16'h0, 10'h200 | 10'(s), 3'h0, s[0], 2'(s)}, rd, er);
         repeat (2) @(posedge pclk);
         @(negedge pclk);
         check("delay", chan1_delay_trim, 32'h200 | s);
         check("route", chan1_input_route, 32'h1 << s);
         check("bypass", chan1_dc_filter_bypass, s & 1);
         check("dc setting", chan1_dc_filter_setting, s[0] ? 32'h0 : 32'hA);
         check("global dc", global_dc_filter_setting, 32'hA);
      end
      $display("test channel setup done");
      run_cal(1'h0, 24'h000100, 24'h800000, 24'h001000);
      run_cal(1'h0, 24'hFFFF80, 24'hC00000, 24'h000080);
      run_cal(1'h0, 24'h000000, 24'hFFFF00, 24'h700000);
      run_cal(1'h0, 24'h000000, 24'hFFFF00, 24'h900000);
      run_cal(1'h1, 24'h400000, 24'h800000, 24'h900000);
      run_cal(1'h1, 24'hFFFFFE, 24'h800000, 24'h000010);
      run_cal(1'h1, 24'h000000, 24'h800000, 24'h123456);
      $display("test trim datapath done");
      stop_test();
   end
endmodule // adc_channel_calibration_regs_test
